//--- rtl/sram_page_select.sv
`timescale 1ns/1ns
// Behaviour
// [R1] stack page resets zero, writes apply immediately
// [R2] stack accesses use stack page only
// [R3] mode 11b sends indexed to stack page
// [R4] index page used only in mode 10b
// [R5] post-increment read data uses read pointer
// [R6] post-increment write data uses write pointer
// [R7] post-increment pointer byte from current page; code uses page 0 in modes 00b and 01b
// [R8] post-increment pointers ignore paging mode bits
// [R9] supervisory call clears paging mode bits
// [R10] supervisory return restores saved flags
// [R11] post-increment pointers stay active during call
// [R12] software keeps stack page stable
// [R13] five pointers hold bit 0, reset zero
// [R14] mode table selects current and indexed pages
// [R15] mode resets 00b, interrupt saves and clears
// [R16] upper mode bit forces current page
// [R17] pointer bits 7 to 1 read zero
// [R18] pointer writes affect next access
module sram_page_select (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire page_sel_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // core events
    input wire logic sv_call,
    input wire logic sv_return,
    input wire logic irq_entry,
    input wire logic irq_return,
    // core access
    input wire page_sel_pkg::core_access_s core_acc,
    // sram side
    output page_sel_pkg::sram_access_s sram_acc,
    output logic [1:0] paging_mode_bits
);

    ////////////////////////////////////////////////////////////////////
    // registers

    logic current_page_pointer_r;
    logic stack_page_pointer_r;
    logic index_page_pointer_r;
    logic postinc_read_page_pointer_r;
    logic postinc_write_page_pointer_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] sv_saved_r;
    logic [7:0] irq_saved_r;
    logic [7:0] reg_rdata_nxt;
    logic wr_cur, wr_stk, wr_idx, wr_mvr, wr_mvw, wr_flags;

    assign wr_cur = reg_req.wr && reg_req.addr == page_sel_pkg::OFF_CUR_PAGE;
    assign wr_stk = reg_req.wr && reg_req.addr == page_sel_pkg::OFF_STACK_PAGE;
    assign wr_idx = reg_req.wr && reg_req.addr == page_sel_pkg::OFF_INDEX_PAGE;
    assign wr_mvr = reg_req.wr && reg_req.addr == page_sel_pkg::OFF_MVR_PAGE;
    assign wr_mvw = reg_req.wr && reg_req.addr == page_sel_pkg::OFF_MVW_PAGE;
    assign wr_flags = reg_req.wr && reg_req.addr == page_sel_pkg::OFF_FLAGS;

    // only bit 0 is stored; upper write bits dropped
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            current_page_pointer_r <= page_sel_pkg::PTR_RESET[page_sel_pkg::PAGE_BIT]; // R13
            stack_page_pointer_r <= page_sel_pkg::PTR_RESET[page_sel_pkg::PAGE_BIT]; // R1
            index_page_pointer_r <= page_sel_pkg::PTR_RESET[page_sel_pkg::PAGE_BIT];
            postinc_read_page_pointer_r <= page_sel_pkg::PTR_RESET[page_sel_pkg::PAGE_BIT];
            postinc_write_page_pointer_r <= page_sel_pkg::PTR_RESET[page_sel_pkg::PAGE_BIT];
        end else begin
            if (wr_cur) current_page_pointer_r <= reg_req.wdata[page_sel_pkg::PAGE_BIT];
            if (wr_stk) stack_page_pointer_r <= reg_req.wdata[page_sel_pkg::PAGE_BIT]; // R1
            if (wr_idx) index_page_pointer_r <= reg_req.wdata[page_sel_pkg::PAGE_BIT];
            if (wr_mvr) postinc_read_page_pointer_r <= reg_req.wdata[page_sel_pkg::PAGE_BIT];
            if (wr_mvw) postinc_write_page_pointer_r <= reg_req.wdata[page_sel_pkg::PAGE_BIT]; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags: call and interrupt entry save then clear, returns restore

    // events outrank a software flags write in the same cycle
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) flags_nxt = reg_req.wdata;
        if (sv_return) flags_nxt = sv_saved_r; // R10
        else if (irq_return) flags_nxt = irq_saved_r; // R15
        if (sv_call) flags_nxt = page_sel_pkg::FLAGS_RESET; // R9
        else if (irq_entry) flags_nxt = page_sel_pkg::FLAGS_RESET; // R15
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) flags_r <= page_sel_pkg::FLAGS_RESET; // R15
        else flags_r <= flags_nxt;
    end

    // one level of save each; nesting is not supported here
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sv_saved_r <= page_sel_pkg::FLAGS_RESET;
            irq_saved_r <= page_sel_pkg::FLAGS_RESET;
        end else begin
            if (sv_call) sv_saved_r <= flags_r; // R10
            if (irq_entry && !sv_call) irq_saved_r <= flags_r; // R15
        end
    end

    assign paging_mode_bits = flags_r[page_sel_pkg::MODE_HI:page_sel_pkg::MODE_LO];

    ////////////////////////////////////////////////////////////////////
    // register read, data in the following cycle

    always_comb begin
        reg_rdata_nxt = 8'h00;
        case (reg_req.addr)
            page_sel_pkg::OFF_CUR_PAGE: reg_rdata_nxt = {7'h00, current_page_pointer_r};
            page_sel_pkg::OFF_STACK_PAGE: reg_rdata_nxt = {7'h00, stack_page_pointer_r};
            page_sel_pkg::OFF_INDEX_PAGE: reg_rdata_nxt = {7'h00, index_page_pointer_r};
            page_sel_pkg::OFF_MVR_PAGE: reg_rdata_nxt = {7'h00, postinc_read_page_pointer_r};
            page_sel_pkg::OFF_MVW_PAGE: reg_rdata_nxt = {7'h00, postinc_write_page_pointer_r};
            page_sel_pkg::OFF_FLAGS: reg_rdata_nxt = flags_r;
            default: reg_rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) reg_rdata <= 8'h00;
        else if (reg_req.rd) reg_rdata <= reg_rdata_nxt; // R17
        else reg_rdata <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // page selection; combinational so a stored write is seen next cycle

    logic page_sel;

    page_mux u_mux (
        .cur_page(current_page_pointer_r),
        .stack_page(stack_page_pointer_r),
        .index_page(index_page_pointer_r),
        .mvr_page(postinc_read_page_pointer_r),
        .mvw_page(postinc_write_page_pointer_r),
        .mode(paging_mode_bits),
        .cls(core_acc.cls),
        .page(page_sel)
    );

    // post-increment pointers are not gated by a cleared mode field
    always_comb begin
        sram_acc.valid = core_acc.valid;
        sram_acc.addr = core_acc.addr;
        sram_acc.page = page_sel; // R18
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_stack_follows_ptr;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.valid && core_acc.cls == page_sel_pkg::ACC_STACK
            |-> sram_acc.page == stack_page_pointer_r;
    endproperty
    a_stack_follows_ptr: assert property (p_stack_follows_ptr) // R2
        else $error("stack page mismatch");

    property p_stack_write_next;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_stk ##1 (core_acc.valid && core_acc.cls == page_sel_pkg::ACC_STACK)
            |-> sram_acc.page == $past(reg_req.wdata[0]);
    endproperty
    a_stack_write_next: assert property (p_stack_write_next) // R1
        else $error("stack write not seen next access");

    property p_idx_mode11;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_INDEXED && paging_mode_bits == 2'b11
            |-> sram_acc.page == stack_page_pointer_r;
    endproperty
    a_idx_mode11: assert property (p_idx_mode11) // R3
        else $error("mode 11 indexed page wrong");

    property p_idx_mode10;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_INDEXED && paging_mode_bits == 2'b10
            |-> sram_acc.page == index_page_pointer_r;
    endproperty
    a_idx_mode10: assert property (p_idx_mode10) // R4
        else $error("mode 10 indexed page wrong");

    property p_mvr;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_POSTINC_READ
            |-> sram_acc.page == postinc_read_page_pointer_r;
    endproperty
    a_mvr: assert property (p_mvr) // R5
        else $error("post-increment read page wrong");

    property p_mvw;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_POSTINC_WRITE
            |-> sram_acc.page == postinc_write_page_pointer_r;
    endproperty
    a_mvw: assert property (p_mvw) // R6
        else $error("post-increment write page wrong");

    property p_postinc_ptr;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_POSTINC_PTR
            |-> sram_acc.page == (paging_mode_bits[1] & current_page_pointer_r);
    endproperty
    a_postinc_ptr: assert property (p_postinc_ptr) // R7
        else $error("post-increment pointer fetch page wrong");

    property p_call_clears;
        @(posedge ref_clk) disable iff (!rst_b)
        sv_call |=> paging_mode_bits == 2'b00;
    endproperty
    a_call_clears: assert property (p_call_clears) // R9
        else $error("call did not clear mode");

    property p_call_restore;
        @(posedge ref_clk) disable iff (!rst_b)
        sv_call ##1 (!sv_call && !irq_entry && !irq_return && !wr_flags)[*2] ##0 sv_return
            |=> flags_r == $past(flags_r, 3);
    endproperty
    a_call_restore: assert property (p_call_restore) // R10
        else $error("flags not restored after call");

    property p_normal_hi;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_NORMAL && paging_mode_bits[1]
            |-> sram_acc.page == current_page_pointer_r;
    endproperty
    a_normal_hi: assert property (p_normal_hi) // R16
        else $error("normal access not on current page");

    property p_upper_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        reg_req.rd && reg_req.addr != page_sel_pkg::OFF_FLAGS |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) // R17
        else $error("pointer upper bits not zero");

    property p_idx_mode00;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_INDEXED && paging_mode_bits == 2'h0
            |-> sram_acc.page == 1'h0;
    endproperty
    a_idx_mode00: assert property (p_idx_mode00) // R14
        else $error("mode 00 indexed page wrong");

    property p_idx_mode01;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_INDEXED && paging_mode_bits == 2'h1
            |-> sram_acc.page == stack_page_pointer_r;
    endproperty
    a_idx_mode01: assert property (p_idx_mode01) // R14
        else $error("mode 01 indexed page wrong");

    property p_normal_lo;
        @(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_NORMAL && !paging_mode_bits[1]
            |-> sram_acc.page == 1'h0;
    endproperty
    a_normal_lo: assert property (p_normal_lo) // R14
        else $error("normal access not on page 0");

    property p_irq_clears;
        @(posedge ref_clk) disable iff (!rst_b)
        irq_entry |=> paging_mode_bits == page_sel_pkg::MODE_RESET;
    endproperty
    a_irq_clears: assert property (p_irq_clears) // R15
        else $error("interrupt entry did not clear mode");

    property p_irq_restore;
        @(posedge ref_clk) disable iff (!rst_b)
        (irq_entry && !sv_call) ##1 (!sv_call && !sv_return && !irq_entry && !wr_flags)[*2]
            ##0 irq_return |=> flags_r == $past(flags_r, 3);
    endproperty
    a_irq_restore: assert property (p_irq_restore) // R15
        else $error("flags not restored after interrupt");

    property p_cur_write_next;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_cur |=> current_page_pointer_r == $past(reg_req.wdata[page_sel_pkg::PAGE_BIT]);
    endproperty
    a_cur_write_next: assert property (p_cur_write_next) // R18
        else $error("current page write not taken");

    property p_idx_write_next;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_idx |=> index_page_pointer_r == $past(reg_req.wdata[page_sel_pkg::PAGE_BIT]);
    endproperty
    a_idx_write_next: assert property (p_idx_write_next) // R18
        else $error("index page write not taken");

    c_call: cover property (@(posedge ref_clk) disable iff (!rst_b) sv_call ##[1:8] sv_return);
    c_call_back: cover property (@(posedge ref_clk) disable iff (!rst_b) sv_call ##2 sv_return);
    c_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) irq_entry ##[1:8] irq_return);
    c_idx10: cover property (@(posedge ref_clk) disable iff (!rst_b)
        core_acc.cls == page_sel_pkg::ACC_INDEXED && paging_mode_bits == 2'b10);
    c_stack_write: cover property (@(posedge ref_clk) disable iff (!rst_b)
        wr_stk ##1 (core_acc.valid && core_acc.cls == page_sel_pkg::ACC_STACK));

endmodule

//--- rtl/page_sel_pkg.sv
package page_sel_pkg;

    // register offsets in the core register space
    localparam logic [7:0] OFF_CUR_PAGE = 8'hD0;
    localparam logic [7:0] OFF_STACK_PAGE = 8'hD1;
    localparam logic [7:0] OFF_INDEX_PAGE = 8'hD3;
    localparam logic [7:0] OFF_MVR_PAGE = 8'hD4;
    localparam logic [7:0] OFF_MVW_PAGE = 8'hD5;
    localparam logic [7:0] OFF_FLAGS = 8'hF7;

    // field positions and reset values
    localparam int PAGE_BIT = 0;
    localparam int MODE_LO = 6;
    localparam int MODE_HI = 7;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // paging modes held in flags[7:6]
    typedef enum logic [1:0] {
        MODE_PAGE0 = 2'b00,
        MODE_P0_STACK = 2'b01,
        MODE_CUR_INDEX = 2'b10,
        MODE_CUR_STACK = 2'b11
    } paging_mode_e;

    // class of the access the core is making
    typedef enum logic [2:0] {
        ACC_NORMAL = 3'b000,
        ACC_STACK = 3'b001,
        ACC_INDEXED = 3'b010,
        ACC_POSTINC_PTR = 3'b011,
        ACC_POSTINC_READ = 3'b100,
        ACC_POSTINC_WRITE = 3'b101
    } access_class_e;

    typedef struct packed {
        logic valid;
        access_class_e cls;
        logic [7:0] addr;
    } core_access_s;

    typedef struct packed {
        logic valid;
        logic page;
        logic [7:0] addr;
    } sram_access_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

//--- rtl/page_mux.sv
`timescale 1ns/1ns
module page_mux (
    // pointers
    input wire logic cur_page,
    input wire logic stack_page,
    input wire logic index_page,
    input wire logic mvr_page,
    input wire logic mvw_page,
    input wire logic [1:0] mode,
    // access class
    input wire page_sel_pkg::access_class_e cls,
    // selected page
    output logic page
);

    always_comb begin
        case (cls)
            page_sel_pkg::ACC_STACK: begin
                page = stack_page; // R2
            end
            page_sel_pkg::ACC_INDEXED: begin
                case (mode)
                    page_sel_pkg::MODE_P0_STACK: page = stack_page; // R14
                    page_sel_pkg::MODE_CUR_INDEX: page = index_page; // R4
                    page_sel_pkg::MODE_CUR_STACK: page = stack_page; // R3
                    default: page = 1'b0;
                endcase
            end
            // post-increment data pages ignore the mode field
            page_sel_pkg::ACC_POSTINC_READ: page = mvr_page; // R5 R8 R11
            page_sel_pkg::ACC_POSTINC_WRITE: page = mvw_page; // R6 R8 R11
            // normal access and the post-increment pointer fetch use the current page in modes 10b and 11b, page 0 otherwise
            default: page = mode[1] ? cur_page : 1'b0; // R7 R16
        endcase
    end

endmodule

//--- tb/core_model.sv
`timescale 1ns/1ns
module core_model (
    // clock
    input wire logic ref_clk,
    // accesses towards the page selector
    output page_sel_pkg::core_access_s core_acc
);
    initial core_acc = '{valid: 1'h0, cls: page_sel_pkg::ACC_NORMAL, addr: 8'hA5};
    task automatic issue(input page_sel_pkg::access_class_e c, input logic [7:0] a);
        @(posedge ref_clk);
        core_acc <= '{valid: 1'h1, cls: c, addr: a};
    endtask
    // idle address is inverted so a stale value never passes for a live one
    task automatic idle;
        @(posedge ref_clk);
        core_acc <= '{valid: 1'h0, cls: core_acc.cls, addr: ~core_acc.addr};
    endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic ref_clk;
    logic rst_b;
    page_sel_pkg::reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic [3:0] ev;
    page_sel_pkg::core_access_s core_acc;
    page_sel_pkg::sram_access_s sram_acc;
    logic [1:0] paging_mode_bits;
    int num_errors;
    int tests_run;
    logic [7:0] offs [5];
    logic ptr [5];
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    sram_page_select dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .sv_call(ev[3]), .sv_return(ev[2]), .irq_entry(ev[1]),
        .irq_return(ev[0]), .core_acc(core_acc), .sram_acc(sram_acc),
        .paging_mode_bits(paging_mode_bits));
    core_model core (.ref_clk(ref_clk), .core_acc(core_acc));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge ref_clk);
        reg_req.wr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge ref_clk);
        reg_req.rd <= 1'h0;
        #1;
        cmp8(reg_rdata, exp, "rdata");
    endtask
    task automatic acc_chk(input page_sel_pkg::access_class_e c, input logic e);
        core.issue(c, {5'h0C, c});
        #1;
        cmp8({7'h00, sram_acc.page}, {7'h00, e}, "page");
        cmp8(sram_acc.addr, {5'h0C, c}, "addr");
        cmp8({7'h00, sram_acc.valid}, 8'h01, "valid");
    endtask
    task automatic mode_chk(input logic [1:0] e);
        #1;
        cmp8({6'h00, paging_mode_bits}, {6'h00, e}, "mode");
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge ref_clk);
        ev <= m;
        @(posedge ref_clk);
        ev <= 4'h0;
        #1;
    endtask
    task automatic set_ptrs(input logic [4:0] v);
        for (int i = 0; i < 5; i++) begin
            ptr[i] = v[i];
            reg_wr(offs[i], {7'h00, v[i]});
        end
    endtask
    // order: current, stack, index, post-increment read, post-increment write
    function automatic logic exp_page(input logic [1:0] m, input page_sel_pkg::access_class_e c);
        case (c)
            page_sel_pkg::ACC_STACK: return ptr[1];
            page_sel_pkg::ACC_INDEXED: return (m == 2'h2) ? ptr[2] : (m[0] ? ptr[1] : 1'h0);
            page_sel_pkg::ACC_POSTINC_READ: return ptr[3];
            page_sel_pkg::ACC_POSTINC_WRITE: return ptr[4];
            default: return m[1] ? ptr[0] : 1'h0;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 5; i++) reg_chk(offs[i], 8'h00);
        reg_chk(page_sel_pkg::OFF_FLAGS, 8'h00);
        reg_chk(8'hD2, 8'h00);
        mode_chk(2'h0);
        acc_chk(page_sel_pkg::ACC_STACK, 1'h0);
        core.idle();
        #1;
        cmp8({7'h00, sram_acc.valid}, 8'h00, "valid");
        $display("test reset done");
    endtask
    task automatic t_bits;
        for (int i = 0; i < 5; i++) begin
            reg_wr(offs[i], 8'hFF);
            reg_chk(offs[i], 8'h01);
            reg_wr(offs[i], 8'hFE);
            reg_chk(offs[i], 8'h00);
        end
        $display("test pointer bits done");
    endtask
    task automatic t_modes;
        for (int p = 0; p < 2; p++) begin
            set_ptrs(p ? 5'h0A : 5'h15);
            for (int m = 0; m < 4; m++) begin
                reg_wr(page_sel_pkg::OFF_FLAGS, {m[1:0], 6'h00});
                mode_chk(m[1:0]);
                for (int c = 0; c < 6; c++)
                    acc_chk(page_sel_pkg::access_class_e'(c[2:0]),
                        exp_page(m[1:0], page_sel_pkg::access_class_e'(c[2:0])));
            end
        end
        $display("test mode table done");
    endtask
    // the stack access stays on the bus while the write lands
    task automatic t_stack_now;
        set_ptrs(5'h00);
        acc_chk(page_sel_pkg::ACC_STACK, 1'h0);
        reg_wr(page_sel_pkg::OFF_STACK_PAGE, 8'h01);
        #1;
        cmp8({7'h00, sram_acc.page}, 8'h01, "stack page");
        reg_wr(page_sel_pkg::OFF_STACK_PAGE, 8'h00);
        #1;
        cmp8({7'h00, sram_acc.page}, 8'h00, "stack page");
        $display("test stack write done");
    endtask
    task automatic t_calls;
        for (int k = 0; k < 2; k++) begin
            set_ptrs(5'h1B);
            reg_wr(page_sel_pkg::OFF_FLAGS, 8'hC0);
            pulse(k ? 4'h2 : 4'h8);
            mode_chk(2'h0);
            acc_chk(page_sel_pkg::ACC_INDEXED, 1'h0);
            acc_chk(page_sel_pkg::ACC_NORMAL, 1'h0);
            acc_chk(page_sel_pkg::ACC_POSTINC_READ, 1'h1);
            acc_chk(page_sel_pkg::ACC_POSTINC_WRITE, 1'h1);
            reg_wr(page_sel_pkg::OFF_FLAGS, 8'h40);
            pulse(k ? 4'h1 : 4'h4);
            mode_chk(2'h3);
            acc_chk(page_sel_pkg::ACC_INDEXED, 1'h1);
        end
        reg_wr(page_sel_pkg::OFF_FLAGS, 8'h80);
        // call then return, entry then return, each two cycles apart
        pulse(4'h8);
        mode_chk(2'h0);
        pulse(4'h4);
        mode_chk(2'h2);
        pulse(4'h2);
        mode_chk(2'h0);
        pulse(4'h1);
        mode_chk(2'h2);
        $display("test call and interrupt done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("unexpected at %0t: run timed out", $time);
        summarize();
    end
    initial begin
        rst_b = 1'h0;
        reg_req = '0;
        ev = 4'h0;
        num_errors = 0;
        tests_run = 0;
        offs = '{page_sel_pkg::OFF_CUR_PAGE, page_sel_pkg::OFF_STACK_PAGE,
            page_sel_pkg::OFF_INDEX_PAGE, page_sel_pkg::OFF_MVR_PAGE, page_sel_pkg::OFF_MVW_PAGE};
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'h1;
        t_reset();
        t_bits();
        t_modes();
        t_stack_now();
        t_calls();
        summarize();
    end
endmodule
